/* File: tb/tb_top.sv */
// Self-checking bench for the pattern generator frame geometry.
// Assumes byte register access by offset and a valid/ready video sink.
`timescale 1ns/1ps
module tb_top
    import tpfg_pkg::*;
;
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       vid_valid;
    logic       vid_ready = 1'b0;
    tpfg_word_t vid_word;
    int         n_fail    = 0;
    int         tests_run = 0;
    int         cyc       = 0;
    int         sc        = 0;
    logic [7:0] geo_a [7] = '{REG_LINE_LOW, REG_BAR_HIGH, REG_BAR_LOW,
        REG_ACT_HIGH, REG_ACT_LOW, REG_TOT_HIGH, REG_TOT_LOW};
    logic [7:0] geo_r [7] = '{LINE_LOW_RST, BAR_HIGH_RST, BAR_LOW_RST,
        ACT_HIGH_RST, ACT_LOW_RST, TOT_HIGH_RST, TOT_LOW_RST};
    // Line 9 bytes, bars of 2, four bars, 2 active of 6 total, vbp 1, vfp 2.
    logic [7:0] cfg_a [11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
        8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'h02};
    logic [7:0] cfg_d [11] = '{8'h00, 8'h09, 8'h00, 8'h02, 8'h00, 8'h02,
        8'h00, 8'h06, 8'h01, 8'h02, 8'h20};
    logic [10:0] exp_q [$];

    tpfg_top #(.FIFO_DEPTH(4)) i_tpfg_top (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .vid_valid(vid_valid), .vid_ready(vid_ready), .vid_word(vid_word));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Read issued in the cycle right after a write when do_wr is set.
    task automatic wr_rd(input logic do_wr, input logic [7:0] a,
                         input logic [7:0] d, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = do_wr;
        if (do_wr) begin
            @(negedge clk);
            reg_wr = 1'b0;
        end
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({3'h0, reg_rdata}, {3'h0, e});
    endtask

    // The word is taken at the posedge after the negedge that raised ready.
    task automatic pop(output logic [10:0] w);
        w = 11'h7ff;
        for (int k = 0; k < 100; k++) begin
            @(negedge clk);
            vid_ready = (sc % 4 != 3);
            sc++;
            if (vid_ready && vid_valid === 1'b1) begin
                w = vid_word;
                break;
            end
        end
    endtask

    task automatic push(input tpfg_kind_t k, input logic e,
                        input logic [7:0] d);
        exp_q.push_back({k, e, d});
    endtask

    initial begin
        logic [10:0] w;
        logic [10:0] e;
        int          b;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            wr_rd(1'b0, geo_a[i], 8'h00, geo_r[i]);
        end
        wr_rd(1'b0, REG_CTL, 8'h00, CTL_RST);
        wr_rd(1'b0, REG_CFG, 8'h00, CFG_RST);
        wr_rd(1'b1, 8'h03, 8'hff, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr_rd(1'b1, geo_a[i], 8'ha5 ^ 8'(i), 8'ha5 ^ 8'(i));
        end
        $display("test registers done");
        for (int i = 0; i < 11; i++) begin
            wr(cfg_a[i], cfg_d[i]);
        end
        repeat (5) @(negedge clk);
        chk({10'h0, vid_valid}, 11'h0);
        push(KIND_START, 1'b0, 8'h00);
        push(KIND_BLANK, 1'b1, 8'h00);
        for (int l = 0; l < 2; l++) begin
            for (int i = 0; i < 9; i++) begin
                b = (i / 2 > 3) ? 3 : i / 2;
                push(KIND_DATA, i == 8, COLOR_RST[b]);
            end
        end
        push(KIND_BLANK, 1'b1, 8'h00);
        push(KIND_BLANK, 1'b1, 8'h00);
        push(KIND_END, 1'b0, 8'h00);
        push(KIND_BLANK, 1'b1, 8'h00);
        wr(REG_CTL, 8'h01);
        // Sink stalls first so the FIFO fills and the generator waits.
        repeat (15) @(negedge clk);
        chk({10'h0, vid_valid}, 11'h1);
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            pop(w);
            if (e[10:9] == KIND_DATA) begin
                chk(w, e);
            end else if (e[10:9] == KIND_BLANK) begin
                chk({w[10:8], 8'h0}, {e[10:8], 8'h0});
            end else begin
                chk({w[10:9], 9'h0}, {e[10:9], 9'h0});
            end
        end
        $display("test frame done");
        // Stall the sink so the next frame's start marker waits at the head.
        @(negedge clk);
        vid_ready = 1'b0;
        wr(REG_CTL, 8'h00);
        b = 0;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            vid_ready = 1'b1;
            if (vid_valid === 1'b1 && b == 0) begin
                chk({vid_word.kind, 9'h0}, {KIND_START, 9'h0});
                b = 1;
            end
        end
        repeat (20) @(negedge clk);
        chk({10'h0, vid_valid}, 11'h0);
        $display("test disable done");
        wr(REG_ACT_LOW, 8'h01);
        wr(REG_TOT_LOW, 8'h01);
        wr(REG_LINE_LOW, 8'h05);
        // Fixed mode with a block of three colors and no blanking lines.
        wr(REG_CFG, 8'h83);
        push(KIND_START, 1'b0, 8'h00);
        for (int i = 0; i < 5; i++) begin
            push(KIND_DATA, i == 4, COLOR_RST[i % 3]);
        end
        push(KIND_END, 1'b0, 8'h00);
        wr(REG_CTL, 8'h01);
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            pop(w);
            chk(w, e);
        end
        $display("test fixed done");
        print_verdict();
    end
endmodule

/* File: tb/tpfg_monitor.sv */
// Concurrent checks on the ports of the pattern generator top.
// Assumes it is bound to tpfg_top and sees only that module's ports.
`timescale 1ns/1ps
module tpfg_monitor
    import tpfg_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       vid_valid,
    input wire logic       vid_ready,
    input wire tpfg_word_t vid_word
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_write_low;
        reg_wr && !reg_rd && reg_addr == REG_LINE_LOW;
    endsequence
    sequence s_read_low;
        reg_rd && !reg_wr && reg_addr == REG_LINE_LOW;
    endsequence

    a_line_readback: assert property (
        s_write_low ##1 s_read_low |=> reg_rdata == $past(reg_wdata, 2))
        else $error("line length low byte did not read back");
    a_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (
        reg_rd && (reg_addr == 8'h03 || reg_addr > 8'h1f)
        |=> reg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");
    a_reset_quiet: assert property (
        $fell(rst) |-> !vid_valid && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    a_blank_eol: assert property (
        vid_valid && vid_word.kind == KIND_BLANK |-> vid_word.eol)
        else $error("blank line word without end of line");
    a_stall_hold: assert property (
        vid_valid && !vid_ready |=> vid_valid && $stable(vid_word))
        else $error("video word changed while stalled");
    a_ctl_reserved: assert property (
        reg_rd && reg_addr == REG_CTL |=> reg_rdata[7:1] == 7'h00)
        else $error("control reserved bits read nonzero");
    a_cfg_reserved: assert property (
        reg_rd && reg_addr == REG_CFG |=> !reg_rdata[6])
        else $error("config reserved bit read nonzero");
endmodule

bind tpfg_top tpfg_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_tpfg_monitor (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vid_valid(vid_valid), .vid_ready(vid_ready), .vid_word(vid_word));

/* File: verilog/tpfg_fifo.sv */
// Shift-register FIFO whose head word and flags are all flip-flops.
// Assumes the single system clock and an active high async reset.
`timescale 1ns/1ps
module tpfg_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        valid;
    } tpfg_fifo_st_t;

    tpfg_fifo_st_t s_q;
    tpfg_fifo_st_t s_d;

    always_comb begin
        logic          pop;
        logic          push;
        logic [CW-1:0] slot;
        pop  = s_q.valid & out_ready;
        push = in_valid & ~s_q.full;
        slot = s_q.cnt - CW'(pop);
        s_d  = s_q;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_d.mem[i] = s_q.mem[i+1];
            end
        end
        if (push) begin
            s_d.mem[slot] = in_data;
        end
        s_d.cnt   = slot + CW'(push);
        s_d.full  = (s_d.cnt == CW'(DEPTH));
        s_d.valid = (s_d.cnt != '0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready  = ~s_q.full;
    assign out_valid = s_q.valid;
    assign out_data  = s_q.mem[0];
endmodule

/* File: verilog/tpfg_pkg.sv */
// Shared constants and carriers of the test pattern frame geometry block.
// Assumes one clock domain and byte-wide register access by offset.
package tpfg_pkg;

    localparam logic [7:0] REG_CTL         = 8'h01;
    localparam logic [7:0] REG_CFG         = 8'h02;
    localparam logic [7:0] REG_LINE_HIGH   = 8'h04;
    localparam logic [7:0] REG_LINE_LOW    = 8'h05;
    localparam logic [7:0] REG_BAR_HIGH    = 8'h06;
    localparam logic [7:0] REG_BAR_LOW     = 8'h07;
    localparam logic [7:0] REG_ACT_HIGH    = 8'h08;
    localparam logic [7:0] REG_ACT_LOW     = 8'h09;
    localparam logic [7:0] REG_TOT_HIGH    = 8'h0a;
    localparam logic [7:0] REG_TOT_LOW     = 8'h0b;
    localparam logic [7:0] REG_VBP         = 8'h0e;
    localparam logic [7:0] REG_VFP         = 8'h0f;
    localparam logic [3:0] REG_COLOR_PAGE  = 4'h1;

    localparam int CTL_ON_BIT    = 0;
    localparam int CFG_FIXED_BIT = 7;
    localparam int CFG_NBAR_LSB  = 4;
    localparam int CFG_BLK_LSB   = 0;
    localparam int NUM_COLORS    = 16;

    localparam logic [7:0] CTL_RST       = 8'h00;
    localparam logic [7:0] CFG_RST       = 8'h33;
    localparam logic [7:0] LINE_HIGH_RST = 8'h07;
    localparam logic [7:0] LINE_LOW_RST  = 8'h80;
    localparam logic [7:0] BAR_HIGH_RST  = 8'h00;
    localparam logic [7:0] BAR_LOW_RST   = 8'hf0;
    localparam logic [7:0] ACT_HIGH_RST  = 8'h01;
    localparam logic [7:0] ACT_LOW_RST   = 8'he0;
    localparam logic [7:0] TOT_HIGH_RST  = 8'h02;
    localparam logic [7:0] TOT_LOW_RST   = 8'h0d;
    localparam logic [7:0] VBP_RST       = 8'h21;
    localparam logic [7:0] VFP_RST       = 8'h0a;
    // Colors above the fourth reset to zero.
    localparam logic [NUM_COLORS-1:0][7:0] COLOR_RST =
        {96'h0, 32'h7ff033aa};

    typedef struct packed {
        logic                         on;
        logic                         fixed;
        logic [1:0]                   nbar;
        logic [3:0]                   blk;
        logic [15:0]                  line;
        logic [15:0]                  bar;
        logic [15:0]                  act;
        logic [15:0]                  tot;
        logic [7:0]                   vbp;
        logic [7:0]                   vfp;
        logic [NUM_COLORS-1:0][7:0]   color;
    } tpfg_cfg_t;

    localparam tpfg_cfg_t CFG_RESET = '{
        on:    CTL_RST[CTL_ON_BIT],
        fixed: CFG_RST[CFG_FIXED_BIT],
        nbar:  CFG_RST[CFG_NBAR_LSB+:2],
        blk:   CFG_RST[CFG_BLK_LSB+:4],
        line:  {LINE_HIGH_RST, LINE_LOW_RST},
        bar:   {BAR_HIGH_RST, BAR_LOW_RST},
        act:   {ACT_HIGH_RST, ACT_LOW_RST},
        tot:   {TOT_HIGH_RST, TOT_LOW_RST},
        vbp:   VBP_RST,
        vfp:   VFP_RST,
        color: COLOR_RST
    };

    typedef enum logic [1:0] {
        KIND_START = 2'b00,
        KIND_BLANK = 2'b01,
        KIND_DATA  = 2'b10,
        KIND_END   = 2'b11
    } tpfg_kind_t;

    typedef struct packed {
        tpfg_kind_t  kind;
        logic        eol;
        logic [7:0]  data;
    } tpfg_word_t;

endpackage

/* File: verilog/tpfg_regs.sv */
// Byte-wide register file of the pattern generator geometry and colors.
// Assumes one access per cycle; read data is registered one cycle later.
`timescale 1ns/1ps
module tpfg_regs
    import tpfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output tpfg_cfg_t       cfg
);
    typedef struct packed {
        tpfg_cfg_t  cfg;
        logic [7:0] rdata;
    } tpfg_regs_st_t;

    tpfg_regs_st_t s_q;
    tpfg_regs_st_t s_d;

    function automatic logic [7:0] readback(tpfg_cfg_t c, logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            REG_CTL:       v = {7'h00, c.on};
            REG_CFG:       v = {c.fixed, 1'b0, c.nbar, c.blk};
            REG_LINE_HIGH: v = c.line[15:8];
            REG_LINE_LOW:  v = c.line[7:0];
            REG_BAR_HIGH:  v = c.bar[15:8];
            REG_BAR_LOW:   v = c.bar[7:0];
            REG_ACT_HIGH:  v = c.act[15:8];
            REG_ACT_LOW:   v = c.act[7:0];
            REG_TOT_HIGH:  v = c.tot[15:8];
            REG_TOT_LOW:   v = c.tot[7:0];
            REG_VBP:       v = c.vbp;
            REG_VFP:       v = c.vfp;
            default: begin
                if (a[7:4] == REG_COLOR_PAGE) begin
                    v = c.color[a[3:0]];
                end
            end
        endcase
        return v;
    endfunction

    always_comb begin
        s_d = s_q;
        if (wr) begin
            case (addr)
                REG_CTL:       s_d.cfg.on = wdata[CTL_ON_BIT];
                REG_CFG: begin
                    s_d.cfg.fixed = wdata[CFG_FIXED_BIT];
                    s_d.cfg.nbar  = wdata[CFG_NBAR_LSB+:2];
                    s_d.cfg.blk   = wdata[CFG_BLK_LSB+:4];
                end
                REG_LINE_HIGH: s_d.cfg.line[15:8] = wdata;
                REG_LINE_LOW:  s_d.cfg.line[7:0]  = wdata; // R01
                REG_BAR_HIGH:  s_d.cfg.bar[15:8]  = wdata; // R03
                REG_BAR_LOW:   s_d.cfg.bar[7:0]   = wdata; // R03
                REG_ACT_HIGH:  s_d.cfg.act[15:8]  = wdata; // R06
                REG_ACT_LOW:   s_d.cfg.act[7:0]   = wdata; // R06
                REG_TOT_HIGH:  s_d.cfg.tot[15:8]  = wdata; // R08
                REG_TOT_LOW:   s_d.cfg.tot[7:0]   = wdata; // R08
                REG_VBP:       s_d.cfg.vbp        = wdata;
                REG_VFP:       s_d.cfg.vfp        = wdata;
                default: begin
                    if (addr[7:4] == REG_COLOR_PAGE) begin
                        s_d.cfg.color[addr[3:0]] = wdata;
                    end
                end
            endcase
        end
        if (rd) begin
            s_d.rdata = readback(s_q.cfg, addr);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{cfg: CFG_RESET, rdata: 8'h00}; // R02 R05 R07 R09
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign cfg   = s_q.cfg;
endmodule

/* File: verilog/tpfg_top.sv */
// Test pattern frame generator: registers, frame sequencer and output FIFO.
// Assumes the video sink honours valid/ready and one clock for everything.
//
// Contract
// R01: Line length is sixteen bits in bytes; low byte sits at offset 0x5.
// R02: Line length low byte resets to 0x80, giving 1920 bytes per line.
// R03: Bar width is sixteen bits, high at 0x6, low at 0x7.
// R04: The last color bar fills all bytes left in the line.
// R05: Bar width resets to high 0x00 and low 0xf0.
// R06: Active lines per frame at 0x8/0x9; that many data lines are sent.
// R07: Active line count resets to 480, high 0x01, low 0xe0.
// R08: Total lines per frame, blanking included, at 0xa/0xb.
// R09: Total line count resets to high 0x02, low 0x0d.
// R10: Blanking is total minus active lines; values are high:low pairs.
// R11: Frames are made only while the enable bit is one.
// R12: In bar mode each byte carries its bar's programmed color byte.
// R13: Back porch blank lines go between frame start and first data line.
// R14: Front porch blank lines go between last data line and frame end.
`timescale 1ns/1ps
module tpfg_top
    import tpfg_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            vid_valid,
    input  wire logic       vid_ready,
    output tpfg_word_t      vid_word
);
    localparam int WORD_W = $bits(tpfg_word_t);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_BACK   = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_FRONT  = 3'b100,
        ST_END    = 3'b101,
        ST_TAIL   = 3'b110
    } tpfg_state_t;

    typedef struct packed {
        tpfg_state_t  st;
        logic [15:0]  line;
        logic [15:0]  bar;
        logic [3:0]   last_bar;
        logic         fixed;
        logic [3:0]   blk;
        logic [15:0]  act_left;
        logic [15:0]  back_left;
        logic [15:0]  front_left;
        logic [15:0]  tail_left;
        logic [15:0]  byte_left;
        logic [15:0]  bar_left;
        logic [3:0]   idx;
    } tpfg_gen_st_t;

    tpfg_cfg_t    cfg;
    tpfg_gen_st_t s_q;
    tpfg_gen_st_t s_d;
    tpfg_word_t   gen_word;
    logic         gen_valid;
    logic         gen_ready;
    logic         pushed;

    function automatic logic [15:0] min16(logic [15:0] a, logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [15:0] dec16(logic [15:0] a);
        return (a == 16'h0000) ? 16'h0000 : a - 16'h0001;
    endfunction

    // Number of color bars less one, from the two-bit bar count field.
    function automatic logic [3:0] bars_less_one(logic [1:0] code);
        return 4'((5'h01 << code) - 5'h01);
    endfunction

    tpfg_regs u_regs (
        .clk   (clk),
        .rst   (rst),
        .addr  (reg_addr),
        .wdata (reg_wdata),
        .wr    (reg_wr),
        .rd    (reg_rd),
        .rdata (reg_rdata),
        .cfg   (cfg)
    );

    // The word offered to the FIFO depends on the sequencer state and the live color registers.
    always_comb begin
        gen_word      = '0;
        gen_word.kind = KIND_BLANK;
        gen_valid     = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                gen_valid = 1'b0;
            end
            ST_START: begin
                gen_word.kind = KIND_START;
                gen_valid     = 1'b1;
            end
            ST_BACK: begin
                gen_word.eol = 1'b1;
                gen_valid    = (s_q.back_left != 16'h0000); // R13
            end
            ST_ACTIVE: begin
                gen_word.kind = KIND_DATA;
                gen_word.eol  = (s_q.byte_left == 16'h0001);
                gen_word.data = cfg.color[s_q.idx]; // R12
                gen_valid     = (s_q.act_left != 16'h0000) &&
                                (s_q.line != 16'h0000);
            end
            ST_FRONT: begin
                gen_word.eol = 1'b1;
                gen_valid    = (s_q.front_left != 16'h0000); // R14
            end
            ST_END: begin
                gen_word.kind = KIND_END;
                gen_valid     = 1'b1;
            end
            ST_TAIL: begin
                gen_word.eol = 1'b1;
                gen_valid    = (s_q.tail_left != 16'h0000); // R10
            end
            default: begin
                gen_valid = 1'b0;
            end
        endcase
    end

    assign pushed = gen_valid & gen_ready;

    always_comb begin
        logic [15:0] blank;
        logic [15:0] rem;
        blank = 16'h0000;
        rem   = 16'h0000;
        s_d   = s_q;
        unique case (s_q.st)
            ST_IDLE: begin
                if (cfg.on) begin // R11
                    // Geometry is frozen per frame so that a geometry
                    // register write never tears a frame in half.
                    s_d.line     = cfg.line; // R01
                    s_d.bar      = cfg.bar; // R03
                    s_d.last_bar = bars_less_one(cfg.nbar);
                    s_d.fixed    = cfg.fixed;
                    s_d.blk      = cfg.blk;
                    s_d.act_left = cfg.act; // R06
                    if (cfg.tot > cfg.act) begin
                        blank = cfg.tot - cfg.act; // R10
                    end
                    s_d.back_left  = min16(blank, {8'h00, cfg.vbp});
                    rem            = blank - s_d.back_left;
                    s_d.front_left = min16(rem, {8'h00, cfg.vfp});
                    s_d.tail_left  = rem - s_d.front_left;
                    s_d.byte_left  = cfg.line;
                    s_d.bar_left   = cfg.bar;
                    s_d.idx        = 4'h0;
                    s_d.st         = ST_START;
                end
            end
            ST_START: begin
                if (pushed) begin
                    s_d.st = ST_BACK;
                end
            end
            ST_BACK: begin
                if (s_q.back_left == 16'h0000) begin
                    s_d.st = ST_ACTIVE;
                end else if (pushed) begin
                    s_d.back_left = dec16(s_q.back_left); // R13
                end
            end
            ST_ACTIVE: begin
                if (s_q.act_left == 16'h0000) begin
                    s_d.st = ST_FRONT;
                end else if (s_q.line == 16'h0000) begin
                    // An empty line still counts as one active line.
                    s_d.act_left = dec16(s_q.act_left);
                end else if (pushed) begin
                    if (s_q.byte_left == 16'h0001) begin
                        s_d.act_left  = dec16(s_q.act_left); // R06
                        s_d.byte_left = s_q.line;
                        s_d.bar_left  = s_q.bar;
                        s_d.idx       = 4'h0;
                    end else begin
                        s_d.byte_left = s_q.byte_left - 16'h0001; // R01
                        if (s_q.fixed) begin
                            if (s_q.idx + 4'h1 >= s_q.blk) begin
                                s_d.idx = 4'h0;
                            end else begin
                                s_d.idx = s_q.idx + 4'h1;
                            end
                        end else if (s_q.idx == s_q.last_bar) begin
                            // Final bar runs on to the end of the line.
                            s_d.bar_left = s_q.bar_left; // R04
                        end else if (s_q.bar_left <= 16'h0001) begin
                            s_d.idx      = s_q.idx + 4'h1; // R03
                            s_d.bar_left = s_q.bar;
                        end else begin
                            s_d.bar_left = s_q.bar_left - 16'h0001;
                        end
                    end
                end
            end
            ST_FRONT: begin
                if (s_q.front_left == 16'h0000) begin
                    s_d.st = ST_END;
                end else if (pushed) begin
                    s_d.front_left = dec16(s_q.front_left); // R14
                end
            end
            ST_END: begin
                if (pushed) begin
                    s_d.st = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (s_q.tail_left == 16'h0000) begin
                    s_d.st = ST_IDLE;
                end else if (pushed) begin
                    s_d.tail_left = dec16(s_q.tail_left); // R10
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Disabling drops the frame at once; the FIFO still drains
        // the words already queued, so a frame may end without its
        // end marker.
        if (!cfg.on) begin
            s_d.st = ST_IDLE; // R11
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{st: ST_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    tpfg_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (gen_valid),
        .in_ready  (gen_ready),
        .in_data   (gen_word),
        .out_valid (vid_valid),
        .out_ready (vid_ready),
        .out_data  (vid_word)
    );
endmodule
